// [rtl/fan_boost_consts.svh]
// Offsets, field positions, reset values and timing figures of the fan boost block.
`ifndef FAN_BOOST_CONSTS_SVH
`define FAN_BOOST_CONSTS_SVH

// ----------------------------------------------------------------------------
// Register byte offsets on the APB.
// ----------------------------------------------------------------------------
`define FB_OFF_CTRL      8'h00
`define FB_OFF_HYST      8'h04
`define FB_OFF_BOOST_LIM 8'h08
`define FB_OFF_TACH_LIM0 8'h0C
`define FB_OFF_TACH_LIM1 8'h10
`define FB_OFF_TACH_BIND 8'h14
`define FB_OFF_TEMP_RES  8'h18
`define FB_OFF_STAT_B    8'h1C
`define FB_OFF_STAT_H    8'h20
`define FB_OFF_IRQ_MASK  8'h24
`define FB_OFF_LIVE      8'h28

// ----------------------------------------------------------------------------
// Field positions.
// ----------------------------------------------------------------------------
`define FB_CTRL_TACH_EN  0
`define FB_CTRL_TMO_LSB  8
`define FB_BIND_MASK_LSB 8
`define FB_STAT_TACH_LSB 4
`define FB_STAT_BOOST    8
`define FB_STAT_W        9

// ----------------------------------------------------------------------------
// Reset values and codes.
// ----------------------------------------------------------------------------
`define FB_RST_CTRL      16'h0500
`define FB_RST_HYST      4'h4
`define FB_RST_LIM_HI    8'h3C
`define FB_RST_LIM_LO    8'h23
`define FB_RST_TACH_LIM  16'hFFFF
`define FB_RST_BIND      12'h0E4
`define FB_FAULT_CODE    8'h80
`define FB_DUTY_FULL     8'hFF

// ----------------------------------------------------------------------------
// Timing: the hold-off timeout counts in ticks of one millisecond.
// ----------------------------------------------------------------------------
`define FB_CLK_PERIOD_NS 10
`define FB_TICK_NS       1000000
`define FB_TICK_CYCLES   (`FB_TICK_NS / `FB_CLK_PERIOD_NS)

`endif

// [rtl/fan_boost_pkg.sv]
// Types shared by the fan boost and diode fault block.
package fan_boost_pkg;

   // Per-tachometer boost sequencing.
   typedef enum logic [1:0] {
      TB_IDLE,
      TB_ERR,
      TB_HOLD
   } tach_state_t;

endpackage : fan_boost_pkg

// [rtl/fan_boost_and_diode_fault.sv]
// Diode fault capture and fan boost control with an APB register slave.
// Function
// - Check diode open/short before committing a result.
// - Diode fault sets that channel's status bit.
// - Diode fault loads result with fault code.
// - Diode terminals tied together means short fault.
// - Temperature boost forces both PWM outputs full.
// - Boost starts when a zone exceeds its limit.
// - Boost ends at or below limit minus hysteresis.
// - Limits reset to 60 and 35 degrees.
// - Tach boost works only when enabled.
// - Tach error when count exceeds its limit.
// - Unmasked tach error drives bound PWMs full.
// - Masked tach error never boosts a fan.
// - Bound PWMs hold full for timeout after error.
// - Recurring error cancels and later restarts timeout.
// - Limit of fault code masks that channel's check.
// - Temperatures compare as signed one-degree bytes.
// - Status recorded in two independently cleared sets.
//
// The register offsets and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "fan_boost_consts.svh"

module fan_boost_and_diode_fault
   import fan_boost_pkg::*;
#(
   parameter int unsigned TICK_CYCLES = `FB_TICK_CYCLES
) (
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire logic conv_valid_i,
   input wire logic [1:0] conv_chan_i,
   input wire logic [7:0] conv_temp_i,
   input wire logic [3:0] diode_open_i,
   input wire logic [3:0] diode_short_i,
   input wire logic [31:0] zone_temp_i,
   input wire logic [63:0] tach_count_i,
   input wire logic [7:0] pwm_duty_a_i,
   input wire logic [7:0] pwm_duty_b_i,
   output logic [7:0] fan_pwm_out_a_o,
   output logic [7:0] fan_pwm_out_b_o,
   output logic irq_o
);

   // -------------------------------------------------------------------------
   // Registers and internal signals.
   // -------------------------------------------------------------------------
   logic [15:0] ctrl_q;
   logic [3:0] hyst_q;
   logic [31:0] boost_lim_q;
   logic [63:0] tach_lim_q;
   logic [11:0] bind_q;
   logic [31:0] temp_res_q;
   logic [`FB_STAT_W-1:0] stat_b_q;
   logic [`FB_STAT_W-1:0] stat_h_q;
   logic [`FB_STAT_W-1:0] irq_mask_q;
   logic [`FB_STAT_W-1:0] stat_set;
   logic [31:0] prdata_q;
   logic [7:0] pwm_a_q;
   logic [7:0] pwm_b_q;
   logic irq_q;
   logic [7:0] diode_meta_q;
   logic [7:0] diode_sync_q;
   logic [3:0] diode_fault;
   logic [3:0] zone_boost_q;
   logic [3:0] zone_over;
   logic [3:0] tach_err;
   logic [3:0] tach_req;
   logic [3:0] tach_boost;
   logic [31:0] tick_cnt_q;
   logic tick;
   tach_state_t tach_state_q [4];
   logic [7:0] hold_q [4];

   // -------------------------------------------------------------------------
   // APB decode.
   // -------------------------------------------------------------------------
   // Read data is captured in the setup cycle, so the access phase answers at
   // once with data straight from a flip-flop.
   wire setup_w = psel_i & ~penable_i;
   wire wr_w = psel_i & penable_i & pwrite_i;
   wire sel_ctrl = paddr_i == `FB_OFF_CTRL;
   wire sel_hyst = paddr_i == `FB_OFF_HYST;
   wire sel_blim = paddr_i == `FB_OFF_BOOST_LIM;
   wire sel_tl0 = paddr_i == `FB_OFF_TACH_LIM0;
   wire sel_tl1 = paddr_i == `FB_OFF_TACH_LIM1;
   wire sel_bind = paddr_i == `FB_OFF_TACH_BIND;
   wire sel_tres = paddr_i == `FB_OFF_TEMP_RES;
   wire sel_stb = paddr_i == `FB_OFF_STAT_B;
   wire sel_sth = paddr_i == `FB_OFF_STAT_H;
   wire sel_msk = paddr_i == `FB_OFF_IRQ_MASK;
   wire sel_live = paddr_i == `FB_OFF_LIVE;
   wire mapped_w = sel_ctrl | sel_hyst | sel_blim | sel_tl0 | sel_tl1 | sel_bind |
                   sel_tres | sel_stb | sel_sth | sel_msk | sel_live;
   wire tach_en_w = ctrl_q[`FB_CTRL_TACH_EN];
   wire [7:0] timeout_w = ctrl_q[`FB_CTRL_TMO_LSB +: 8];
   wire [3:0] tach_mask_w = bind_q[`FB_BIND_MASK_LSB +: 4];
   wire [31:0] rd_mux_w =
      sel_ctrl ? {16'h0000, ctrl_q} :
      sel_hyst ? {28'h0000000, hyst_q} :
      sel_blim ? boost_lim_q :
      sel_tl0 ? tach_lim_q[31:0] :
      sel_tl1 ? tach_lim_q[63:32] :
      sel_bind ? {20'h00000, bind_q} :
      sel_tres ? temp_res_q :
      sel_stb ? {23'h000000, stat_b_q} :
      sel_sth ? {23'h000000, stat_h_q} :
      sel_msk ? {23'h000000, irq_mask_q} :
      sel_live ? {18'h00000, pwm_b_q == `FB_DUTY_FULL, pwm_a_q == `FB_DUTY_FULL,
                  4'h0, tach_boost, zone_boost_q} : 32'h00000000;

   assign pready_o = 1'b1;
   assign pslverr_o = psel_i & penable_i & ~mapped_w;
   assign prdata_o = prdata_q;

   // Read capture.
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) prdata_q <= 32'h00000000;
      else if (setup_w) prdata_q <= rd_mux_w;
   end

   // Configuration registers.
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         ctrl_q <= `FB_RST_CTRL;
         hyst_q <= `FB_RST_HYST;
         boost_lim_q <= {`FB_RST_LIM_LO, `FB_RST_LIM_LO,
                         `FB_RST_LIM_HI, `FB_RST_LIM_HI};
         tach_lim_q <= {4{`FB_RST_TACH_LIM}};
         bind_q <= `FB_RST_BIND;
         irq_mask_q <= '0;
      end else if (wr_w) begin
         if (sel_ctrl) ctrl_q <= pwdata_i[15:0];
         if (sel_hyst) hyst_q <= pwdata_i[3:0];
         if (sel_blim) boost_lim_q <= pwdata_i;
         if (sel_tl0) tach_lim_q[31:0] <= pwdata_i;
         if (sel_tl1) tach_lim_q[63:32] <= pwdata_i;
         if (sel_bind) bind_q <= pwdata_i[11:0];
         if (sel_msk) irq_mask_q <= pwdata_i[`FB_STAT_W-1:0];
      end
   end

   // -------------------------------------------------------------------------
   // Diode fault capture.
   // -------------------------------------------------------------------------
   // The open and short indications come from the analog front end, so they
   // pass two flip-flops before the commit logic looks at them.
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         diode_meta_q <= 8'h00;
         diode_sync_q <= 8'h00;
      end else begin
         diode_meta_q <= {diode_short_i, diode_open_i};
         diode_sync_q <= diode_meta_q;
      end
   end

   // A short is the two diode terminals tied to each other.
   assign diode_fault = diode_sync_q[3:0] | diode_sync_q[7:4];
   wire conv_fault_w = conv_valid_i & diode_fault[conv_chan_i];

   // Commit each new conversion, replacing it by the fault code on a fault.
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) temp_res_q <= 32'h00000000;
      else if (conv_valid_i)
         temp_res_q[conv_chan_i*8 +: 8] <= conv_fault_w ? `FB_FAULT_CODE : conv_temp_i;
   end

   // -------------------------------------------------------------------------
   // Temperature zone boost with hysteresis.
   // -------------------------------------------------------------------------
   for (genvar z = 0; z < 4; z++) begin : g_zone
      wire [7:0] t_w = zone_temp_i[z*8 +: 8];
      wire [7:0] l_w = boost_lim_q[z*8 +: 8];
      wire logic signed [8:0] ts_w = {t_w[7], t_w};
      wire logic signed [8:0] ls_w = {l_w[7], l_w};
      wire logic signed [8:0] thr_w = ls_w - $signed({5'h00, hyst_q});
      // A fault-code limit masks the zone, and a fault-code reading is no
      // temperature at all, so neither may start or hold a boost.
      wire valid_w = (l_w != `FB_FAULT_CODE) && (t_w != `FB_FAULT_CODE);
      assign zone_over[z] = valid_w && (ts_w > ls_w);
      // Set beats release, so a reading over the limit always holds the boost.
      always_ff @(posedge clk_sys_i) begin
         if (!rst_n_i) zone_boost_q[z] <= 1'b0;
         else if (!valid_w) zone_boost_q[z] <= 1'b0;
         else if (zone_over[z]) zone_boost_q[z] <= 1'b1;
         else if (ts_w <= thr_w) zone_boost_q[z] <= 1'b0;
      end
      AST_HYST_HOLD: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
         zone_boost_q[z] && valid_w && (ts_w > thr_w) |=> zone_boost_q[z])
         else $error("zone boost released above the hysteresis point");
      AST_ZONE_ON: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
         zone_over[z] |=> zone_boost_q[z])
         else $error("zone over its boost limit did not boost");
   end

   // -------------------------------------------------------------------------
   // Tachometer boost with hold-off timeout.
   // -------------------------------------------------------------------------
   // One shared millisecond tick; a hold therefore lasts between N and N+1
   // ticks, which saves a prescaler per fan.
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) tick_cnt_q <= 32'h00000000;
      else if (tick) tick_cnt_q <= 32'h00000000;
      else tick_cnt_q <= tick_cnt_q + 32'h00000001;
   end
   assign tick = tick_cnt_q >= 32'(TICK_CYCLES - 1);

   for (genvar t = 0; t < 4; t++) begin : g_tach
      assign tach_err[t] = tach_count_i[t*16 +: 16] > tach_lim_q[t*16 +: 16];
      assign tach_req[t] = tach_err[t] & tach_en_w & ~tach_mask_w[t];
      assign tach_boost[t] = tach_state_q[t] != TB_IDLE;
      // Each tachometer runs its own error, hold and release sequence.
      always_ff @(posedge clk_sys_i) begin
         if (!rst_n_i) begin
            tach_state_q[t] <= TB_IDLE;
            hold_q[t] <= 8'h00;
         end else if (!tach_en_w || tach_mask_w[t]) begin
            tach_state_q[t] <= TB_IDLE;
            hold_q[t] <= 8'h00;
         end else begin
            case (tach_state_q[t])
               TB_IDLE: if (tach_req[t]) tach_state_q[t] <= TB_ERR;
               TB_ERR: if (!tach_req[t]) begin
                  tach_state_q[t] <= (timeout_w == 8'h00) ? TB_IDLE : TB_HOLD;
                  hold_q[t] <= timeout_w;
               end
               // The count runs down to zero and one more tick ends the hold, so
               // the fan never drops before the whole programmed timeout.
               TB_HOLD: begin
                  if (tach_req[t]) tach_state_q[t] <= TB_ERR;
                  else if (tick && hold_q[t] == 8'h00) tach_state_q[t] <= TB_IDLE;
                  if (tick && hold_q[t] != 8'h00) hold_q[t] <= hold_q[t] - 8'h01;
               end
               default: tach_state_q[t] <= TB_IDLE;
            endcase
         end
      end
      AST_TACH_MASKED: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
         tach_mask_w[t] |=> !tach_boost[t])
         else $error("masked tachometer kept a boost");
      AST_TACH_RETRIG: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
         tach_state_q[t] == TB_HOLD && tach_req[t] |=> tach_state_q[t] == TB_ERR)
         else $error("recurring tach error did not cancel the timeout");
      AST_TACH_HOLD: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
         tach_state_q[t] == TB_ERR && !tach_req[t] && tach_en_w && !tach_mask_w[t]
         && timeout_w != 8'h00 |=> tach_state_q[t] == TB_HOLD && hold_q[t] == $past(timeout_w))
         else $error("tach hold did not start with the programmed timeout");
      // While ticks remain, only a new error may move the sequence on.
      AST_TACH_KEEP: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
         tach_state_q[t] == TB_HOLD && hold_q[t] != 8'h00 && tach_en_w && !tach_mask_w[t]
         |=> tach_boost[t])
         else $error("tach boost ended while the timeout still ran");
      AST_TACH_ERR: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
         tach_req[t] |=> tach_state_q[t] == TB_ERR)
         else $error("tach error did not start a boost");
   end

   // Bound outputs of every boosting tachometer; bit 2t selects output A.
   wire [3:0] bind_a_w = {bind_q[6], bind_q[4], bind_q[2], bind_q[0]};
   wire [3:0] bind_b_w = {bind_q[7], bind_q[5], bind_q[3], bind_q[1]};
   wire boost_a_w = (|zone_boost_q) | (|(tach_boost & bind_a_w));
   wire boost_b_w = (|zone_boost_q) | (|(tach_boost & bind_b_w));

   // PWM duty outputs: full on under a zone boost or a bound tach boost, else the normal duty.
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         pwm_a_q <= 8'h00;
         pwm_b_q <= 8'h00;
      end else begin
         pwm_a_q <= boost_a_w ? `FB_DUTY_FULL : pwm_duty_a_i;
         pwm_b_q <= boost_b_w ? `FB_DUTY_FULL : pwm_duty_b_i;
      end
   end
   assign fan_pwm_out_a_o = pwm_a_q;
   assign fan_pwm_out_b_o = pwm_b_q;

   // -------------------------------------------------------------------------
   // Mirrored status sets and interrupt.
   // -------------------------------------------------------------------------
   // Each set clears on a one written to its own word; a set in the same cycle
   // wins, so no event is lost while the other controller is clearing.
   assign stat_set = {|zone_boost_q, tach_req, conv_fault_w ? 4'(4'h1 << conv_chan_i) : 4'h0};
   wire [`FB_STAT_W-1:0] clr_b_w = (wr_w && sel_stb) ? pwdata_i[`FB_STAT_W-1:0] : '0;
   wire [`FB_STAT_W-1:0] clr_h_w = (wr_w && sel_sth) ? pwdata_i[`FB_STAT_W-1:0] : '0;

   // Both sets take the same events; only their clears are separate.
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         stat_b_q <= '0;
         stat_h_q <= '0;
         irq_q <= 1'b0;
      end else begin
         stat_b_q <= (stat_b_q & ~clr_b_w) | stat_set;
         stat_h_q <= (stat_h_q & ~clr_h_w) | stat_set;
         irq_q <= |((stat_b_q | stat_h_q) & irq_mask_q);
      end
   end
   assign irq_o = irq_q;

   // -------------------------------------------------------------------------
   // Checks on outputs and status.
   // -------------------------------------------------------------------------
   AST_DIODE_CODE: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      conv_fault_w |=> temp_res_q[$past(conv_chan_i)*8 +: 8] == `FB_FAULT_CODE)
      else $error("diode fault did not load the fault code");
   AST_DIODE_STAT: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      conv_fault_w |=> stat_b_q[$past(conv_chan_i)] && stat_h_q[$past(conv_chan_i)])
      else $error("diode fault missing from a status set");
   AST_PWM_FULL: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      (|zone_boost_q) |=> fan_pwm_out_a_o == `FB_DUTY_FULL && fan_pwm_out_b_o == `FB_DUTY_FULL)
      else $error("temperature boost did not force both outputs full");
   AST_PWM_NORMAL: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      !boost_a_w |=> fan_pwm_out_a_o == $past(pwm_duty_a_i))
      else $error("output A did not follow the normal duty");
   AST_PWM_NORMAL_B: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      !boost_b_w |=> fan_pwm_out_b_o == $past(pwm_duty_b_i))
      else $error("output B did not follow the normal duty");
   // A tach boost forces full every output bound to that tachometer.
   AST_TACH_BIND_A: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      (|(tach_boost & bind_a_w)) |=> fan_pwm_out_a_o == `FB_DUTY_FULL)
      else $error("bound tach boost did not force output A full");
   AST_TACH_BIND_B: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      (|(tach_boost & bind_b_w)) |=> fan_pwm_out_b_o == `FB_DUTY_FULL)
      else $error("bound tach boost did not force output B full");
   // An event in the cycle of a clear must still land in both sets.
   AST_STAT_SET: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      stat_set != '0 |=> (stat_b_q & $past(stat_set)) == $past(stat_set)
      && (stat_h_q & $past(stat_set)) == $past(stat_set))
      else $error("a status event was lost from a mirrored set");
   AST_RESET_LIM: assert property (@(posedge clk_sys_i)
      !rst_n_i |=> boost_lim_q == 32'h23233C3C)
      else $error("boost limits wrong after reset");

endmodule : fan_boost_and_diode_fault
`default_nettype wire

// [bench/fan_far_side_model.sv]
// Far-side model: fan tachometers and remote thermal diodes of the fan boost block.
`timescale 1ns/1ps
`default_nettype none

module fan_far_side_model (
   input wire logic clk_sys_i,
   input wire logic [63:0] tach_set_i,
   input wire logic [7:0] diode_mode_i,
   output logic [63:0] tach_count_o,
   output logic [3:0] diode_open_o,
   output logic [3:0] diode_short_o
);
   // ------------------------------------------------------------------
   // Tachometers and diodes
   // ------------------------------------------------------------------
   // A tach count is latched once per cycle, so a new speed shows one cycle late.
   always_ff @(posedge clk_sys_i) begin
      tach_count_o <= tach_set_i;
   end

   // Mode 1 leaves a diode open; mode 2 ties its two terminals together.
   always_comb begin
      for (int c = 0; c < 4; c++) begin
         diode_open_o[c] = (diode_mode_i[2*c +: 2] == 2'h1);
         diode_short_o[c] = (diode_mode_i[2*c +: 2] == 2'h2);
      end
   end
endmodule : fan_far_side_model

`default_nettype wire

// [bench/test_fan_boost_and_diode_fault.sv]
// Self-checking testbench of the fan boost and diode fault block.
`timescale 1ns/1ps
`default_nettype none
`include "fan_boost_consts.svh"

module test_fan_boost_and_diode_fault;
   // ------------------------------------------------------------------
   // Stimulus, design and far side
   // ------------------------------------------------------------------
   logic clk_sys_i, rst_n_i, psel, penable, pwrite, pready, pslverr, conv_valid, irq, err;
   logic [7:0] paddr, temp, duty_a, duty_b, out_a, out_b, diode_mode;
   logic [1:0] chan;
   logic [31:0] pwdata, prdata, zones, rd;
   logic [63:0] tach_set, tach_count;
   logic [3:0] d_open, d_short;
   int bad_count, comparisons;

   // A short tick keeps the hold-off timeouts to tens of cycles.
   fan_boost_and_diode_fault #(.TICK_CYCLES(10)) u_fan_boost_and_diode_fault (
      .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .psel_i(psel), .penable_i(penable),
      .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
      .pready_o(pready), .pslverr_o(pslverr), .conv_valid_i(conv_valid),
      .conv_chan_i(chan), .conv_temp_i(temp), .diode_open_i(d_open),
      .diode_short_i(d_short), .zone_temp_i(zones), .tach_count_i(tach_count),
      .pwm_duty_a_i(duty_a), .pwm_duty_b_i(duty_b), .fan_pwm_out_a_o(out_a),
      .fan_pwm_out_b_o(out_b), .irq_o(irq));

   fan_far_side_model u_fan_far_side_model (
      .clk_sys_i(clk_sys_i), .tach_set_i(tach_set), .diode_mode_i(diode_mode),
      .tach_count_o(tach_count), .diode_open_o(d_open), .diode_short_o(d_short));

   // ------------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------------
   // Verdict and end of run; a timeout also lands here.
   task automatic end_sim();
      $display("comparisons %0d, mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : end_sim

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         bad_count++;
         $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask : check

   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys_i);
   endtask : tick

   // One APB transfer; read data and error are taken at the completing edge.
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk_sys_i);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys_i);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk_sys_i);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (pready !== 1'b1) begin
         bad_count++;
         end_sim();
      end else begin
         rd = prdata;
         err = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask : apb

   task automatic conv(input logic [1:0] c, input logic [7:0] t);
      @(posedge clk_sys_i);
      conv_valid <= 1'b1;
      chan <= c;
      temp <= t;
   endtask : conv

   // Applies zone temps and tach counts, waits, then checks both fan outputs.
   task automatic step(input logic [31:0] z, input logic [63:0] t, input int n,
                       input logic [7:0] a, input logic [7:0] b);
      @(posedge clk_sys_i);
      zones <= z;
      tach_set <= t;
      tick(n);
      check({24'h0, out_a}, {24'h0, a});
      check({24'h0, out_b}, {24'h0, b});
   endtask : step

   // ------------------------------------------------------------------
   // Clock and test sequence
   // ------------------------------------------------------------------
   initial begin
      clk_sys_i = 1'b0;
      forever #5 clk_sys_i = ~clk_sys_i;
   end

   initial begin
      {rst_n_i, psel, penable, pwrite, conv_valid, paddr, pwdata, chan, temp} = '0;
      {zones, tach_set, diode_mode} = '0;
      duty_a = 8'h40;
      duty_b = 8'h55;
      bad_count = 0;
      comparisons = 0;
      tick(2);
      rst_n_i <= 1'b1;
      apb(1'b0, `FB_OFF_BOOST_LIM, 32'h0);
      check(rd, 32'h2323_3C3C);
      // Unmapped address must be refused with an error and zero data.
      apb(1'b0, 8'h2C, 32'h0);
      check({31'h0, err}, 32'h1);
      check(rd, 32'h0);
      // Channel 1 open, channel 2 short, channel 0 healthy, converted back to back.
      diode_mode <= 8'h24;
      tick(4);
      conv(2'h1, 8'h30);
      conv(2'h2, 8'h31);
      conv(2'h0, 8'h19);
      @(posedge clk_sys_i);
      conv_valid <= 1'b0;
      apb(1'b0, `FB_OFF_TEMP_RES, 32'h0);
      check(rd, 32'h0080_8019);
      apb(1'b0, `FB_OFF_STAT_B, 32'h0);
      check(rd, 32'h6);
      diode_mode <= 8'h00;
      tick(4);
      apb(1'b1, `FB_OFF_STAT_B, 32'h6);
      apb(1'b0, `FB_OFF_STAT_B, 32'h0);
      check(rd, 32'h0);
      apb(1'b0, `FB_OFF_STAT_H, 32'h0);
      check(rd, 32'h6);
      apb(1'b1, `FB_OFF_IRQ_MASK, 32'h2);
      tick(2);
      check({31'h0, irq}, 32'h1);
      apb(1'b1, `FB_OFF_STAT_H, 32'h6);
      tick(2);
      check({31'h0, irq}, 32'h0);
      // Zone boost: strict limit, hysteresis, signed compare, masked limit.
      step(32'h0000_003C, 64'h0, 4, 8'h40, 8'h55);
      step(32'h0000_003D, 64'h0, 4, 8'hFF, 8'hFF);
      step(32'h0000_0039, 64'h0, 4, 8'hFF, 8'hFF);
      step(32'h0000_0038, 64'h0, 4, 8'h40, 8'h55);
      step(32'h00C9_0000, 64'h0, 4, 8'h40, 8'h55);
      step(32'h0024_0000, 64'h0, 4, 8'hFF, 8'hFF);
      apb(1'b1, `FB_OFF_BOOST_LIM, 32'h2323_803C);
      step(32'h0000_7D00, 64'h0, 4, 8'h40, 8'h55);
      // Tach boost: tach 0 bound to output A, limit 1000h, timeout 4 ticks.
      apb(1'b1, `FB_OFF_TACH_LIM0, 32'hFFFF_1000);
      apb(1'b1, `FB_OFF_TACH_BIND, 32'h0000_0001);
      step(32'h0, 64'h2000, 5, 8'h40, 8'h55);
      step(32'h0, 64'h1000, 2, 8'h40, 8'h55);
      apb(1'b1, `FB_OFF_CTRL, 32'h0000_0401);
      step(32'h0, 64'h1000, 5, 8'h40, 8'h55);
      step(32'h0, 64'h1001, 5, 8'hFF, 8'h55);
      step(32'h0, 64'h0FFF, 4, 8'hFF, 8'h55);
      step(32'h0, 64'h0FFF, 55, 8'h40, 8'h55);
      // Error comes back mid hold; the hold restarts from the second drop.
      step(32'h0, 64'h1001, 5, 8'hFF, 8'h55);
      step(32'h0, 64'h0FFF, 20, 8'hFF, 8'h55);
      step(32'h0, 64'h1001, 6, 8'hFF, 8'h55);
      step(32'h0, 64'h0FFF, 25, 8'hFF, 8'h55);
      step(32'h0, 64'h0FFF, 30, 8'h40, 8'h55);
      apb(1'b1, `FB_OFF_TACH_BIND, 32'h0000_0003);
      step(32'h0, 64'h1001, 5, 8'hFF, 8'hFF);
      apb(1'b0, `FB_OFF_LIVE, 32'h0);
      check(rd, 32'h0000_3010);
      apb(1'b1, `FB_OFF_TACH_BIND, 32'h0000_0103);
      step(32'h0, 64'h1001, 5, 8'h40, 8'h55);
      end_sim();
   end
endmodule : test_fan_boost_and_diode_fault

`default_nettype wire
